// file: bbe_cfg.svh
// Constants for the branch and breakpoint execute block
`ifndef BBE_CFG_SVH
`define BBE_CFG_SVH
`define BBE_BIC16_TOP 10'h10e
`define BBE_BREAKPOINT_OP_TOP 8'hbe
`define BBE_BXBLX_TOP 8'h47
`define BBE_CB_TOP 4'hb
`define BBE_BL_HI_TOP 5'h1e
`define BBE_SEC_RET_MARK 32'hfeffffff
`define BBE_EXC_RET_TOP 8'hff
`define BBE_EXCEPTION_NUMBER_REG_RESET_NUM 9'h001
`define BBE_STACK_DEC 32'h00000008
`define BBE_STACK_PSR_OFS 32'h00000004
`define BBE_PC_REG 4'hf
`endif

// file: bbe_pkg.sv
// Types for the branch and breakpoint execute block
package bbe_pkg;
    typedef enum logic [1:0] {
        BBE_IDLE = 2'b00,
        BBE_ST_RET = 2'b01,
        BBE_ST_PSR = 2'b10,
        BBE_FINISH = 2'b11
    } bbe_state_t;
    typedef enum logic [1:0] {
        BBE_SH_LSL = 2'b00,
        BBE_SH_LSR = 2'b01,
        BBE_SH_ASR = 2'b10,
        BBE_SH_ROR = 2'b11
    } bbe_shift_t;
endpackage

// file: bbe_exec.sv
// Decode and execute for bit clear, breakpoint, calls, exchanges and compare-branch
//
// Function
// - Bit clear result, N Z C flags, V kept
// - Breakpoint raises monitor trap or halt
// - Breakpoint ignores predication and condition
// - Breakpoint immediate value is ignored
// - Call offset from inverted J xor S
// - Call sets link to next address odd
// - Calls mid predication group are errors
// - Exchange to even target flags invalid state
// - Secure exit decode in non-secure is undefined
// - Link exchange through PC is error
// - Link exchange return is PC minus two
// - Secure call stacks return and status
// - Second store skipped when first faults
// - Stack pointer lowered, link gets marker
// - Secure exit exchange switches to non-secure
// - Exchange to return marker returns exception
// - Exchange through PC faults next instruction
// - Secure exit via PC switches state
// - Compare-branch offset and zero selection
// - Compare-branch in predication group is error
// - Compare-branch keeps condition flags
// - Branch when nonzero differs from zero test
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "bbe_cfg.svh"
module bbe_exec (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic instr_is_32,
    input wire logic cond_pass,
    input wire logic in_pred_group,
    input wire logic last_in_pred_group,
    input wire logic is_secure,
    input wire logic handler_mode,
    input wire logic monitor_mode_sel,
    input wire logic [31:0] pc,
    input wire logic [31:0] rn_val,
    input wire logic [31:0] rm_val,
    input wire logic [31:0] sp_val,
    input wire logic [8:0] exc_num,
    input wire logic secure_fp_active_flag,
    input wire logic [3:0] flags_in,
    input wire logic [1:0] shift_type,
    input wire logic [5:0] shift_amt,
    input wire logic st_done,
    input wire logic st_fault,
    input wire logic sp_limit_fault,
    output logic busy,
    output logic wb_en,
    output logic [3:0] wb_reg,
    output logic [31:0] wb_data,
    output logic flags_en,
    output logic [3:0] flags_out,
    output logic branch_en,
    output logic [31:0] branch_target,
    output logic branch_to_ns,
    output logic exc_return,
    output logic invalid_state_fault_kind,
    output logic undef_fault,
    output logic decode_error,
    output logic halt_free_debug_trap,
    output logic debug_halt_req,
    output logic st_req,
    output logic [31:0] st_addr,
    output logic [31:0] st_data,
    output logic sp_wr_en,
    output logic [31:0] sp_wr_data,
    output logic exception_number_reg_wr_en,
    output logic [8:0] exception_number_reg_wr_data,
    output logic stack_fault
);
    import bbe_pkg::*;

    bbe_state_t state_r, state_nxt;
    logic [31:0] frame_r;
    logic [31:0] ret_r;
    logic [31:0] psr_r;
    logic [31:0] tgt_r;
    logic hmode_r;
    logic go;

    wire [15:0] hw = instr[15:0];
    wire [15:0] lw = instr[31:16];
    wire is_bic16 = !instr_is_32 && hw[15:6] == `BBE_BIC16_TOP;
    wire is_bic32 = instr_is_32 && hw[15:5] == 11'b11101010001;
    wire is_bic = is_bic16 || is_bic32;
    wire is_breakpoint_op = !instr_is_32 && hw[15:8] == `BBE_BREAKPOINT_OP_TOP;
    wire is_bxg = !instr_is_32 && hw[15:8] == `BBE_BXBLX_TOP && hw[1:0] == 2'b00;
    wire is_bx = is_bxg && !hw[7];
    wire is_blx = is_bxg && hw[7];
    wire ns_sel = hw[2];
    wire [3:0] rm_idx = hw[6:3];
    wire is_cb = !instr_is_32 && hw[15:12] == `BBE_CB_TOP && hw[10] == 1'b0 && hw[8];
    wire is_bl = instr_is_32 && hw[15:11] == `BBE_BL_HI_TOP && lw[15:14] == 2'b11 && lw[12];
    wire mid_group = in_pred_group && !last_in_pred_group;
    wire ok = instr_valid && state_r == BBE_IDLE;

    // Fixed upper byte only; imm8 deliberately never read
    wire breakpoint_op_go = ok && is_breakpoint_op;

    wire s_bit = hw[10];
    wire i1 = ~(lw[13] ^ s_bit);
    wire i2 = ~(lw[11] ^ s_bit);
    wire [31:0] bl_off = {{7{s_bit}}, s_bit, i1, i2, hw[9:0], lw[10:0], 1'b0};
    wire [31:0] cb_off = {25'h0000000, hw[9], hw[7:3], 1'b0};
    wire cb_nz = hw[11];
    wire cb_take = cb_nz != (rn_val == 32'h00000000);

    wire xfer_err = (is_bl || is_bxg) && mid_group;
    wire cb_err = is_cb && in_pred_group;
    wire blx_pc_err = is_blx && rm_idx == `BBE_PC_REG;
    wire ns_undef = is_bxg && ns_sel && !is_secure;
    wire any_err = xfer_err || cb_err || blx_pc_err;

    wire [31:0] tgt = rm_val;
    wire [31:0] blx_ret = {pc[31:1] - 31'h00000001, 1'b1};
    wire sec_exit = ns_sel && !tgt[0];
    wire is_fnc_mark = tgt == `BBE_SEC_RET_MARK;
    wire is_exc_mark = tgt[31:24] == `BBE_EXC_RET_TOP;
    wire branch_link_exchange_secure_exit_stack = ok && is_blx && ns_sel && is_secure && !tgt[0] && !any_err && cond_pass;

    // Shifter for the bit clear second operand
    logic [31:0] sh_val;
    logic sh_c;
    always_comb begin
        sh_val = rm_val;
        sh_c = flags_in[1];
        if (shift_amt != 6'h00) begin
            unique case (bbe_shift_t'(shift_type))
                BBE_SH_LSL: {sh_c, sh_val} = {1'b0, rm_val} << shift_amt;
                BBE_SH_LSR: {sh_val, sh_c} = {rm_val, 1'b0} >> shift_amt;
                BBE_SH_ASR: {sh_val, sh_c} = 33'($signed({rm_val, 1'b0}) >>> shift_amt);
                BBE_SH_ROR: begin
                    sh_val = (rm_val >> shift_amt[4:0]) | (rm_val << (6'h20 - {1'b0, shift_amt[4:0]}));
                    sh_c = sh_val[31];
                end
            endcase
        end
    end
    wire [31:0] bic_res = rn_val & ~sh_val;
    wire bic_set = is_bic16 ? !in_pred_group : hw[4];
    wire [3:0] bic_dst = is_bic16 ? {1'b0, hw[2:0]} : lw[11:8];

    // Stacking sequence; the store order is fixed here even though only the slots matter
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BBE_IDLE: if (branch_link_exchange_secure_exit_stack) state_nxt = BBE_ST_RET;
            BBE_ST_RET: if (st_done) state_nxt = st_fault ? BBE_IDLE : BBE_ST_PSR;
            BBE_ST_PSR: if (st_done) state_nxt = st_fault ? BBE_IDLE : BBE_FINISH;
            BBE_FINISH: state_nxt = BBE_IDLE;
        endcase
    end

    assign go = ok && !any_err && !ns_undef && cond_pass;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= BBE_IDLE;
            frame_r <= 32'h00000000;
            ret_r <= 32'h00000000;
            psr_r <= 32'h00000000;
            tgt_r <= 32'h00000000;
            hmode_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (branch_link_exchange_secure_exit_stack) begin
                frame_r <= sp_val - `BBE_STACK_DEC;
                ret_r <= blx_ret;
                psr_r <= {22'h000000, secure_fp_active_flag, exc_num};
                tgt_r <= tgt;
                hmode_r <= handler_mode;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            wb_en <= 1'b0;
            wb_reg <= 4'h0;
            wb_data <= 32'h00000000;
            flags_en <= 1'b0;
            flags_out <= 4'h0;
            branch_en <= 1'b0;
            branch_target <= 32'h00000000;
            branch_to_ns <= 1'b0;
            exc_return <= 1'b0;
            invalid_state_fault_kind <= 1'b0;
            undef_fault <= 1'b0;
            decode_error <= 1'b0;
            halt_free_debug_trap <= 1'b0;
            debug_halt_req <= 1'b0;
            st_req <= 1'b0;
            st_addr <= 32'h00000000;
            st_data <= 32'h00000000;
            sp_wr_en <= 1'b0;
            sp_wr_data <= 32'h00000000;
            exception_number_reg_wr_en <= 1'b0;
            exception_number_reg_wr_data <= 9'h000;
            stack_fault <= 1'b0;
        end else begin
            busy <= state_nxt != BBE_IDLE;
            wb_en <= 1'b0;
            flags_en <= 1'b0;
            branch_en <= 1'b0;
            branch_to_ns <= 1'b0;
            exc_return <= 1'b0;
            invalid_state_fault_kind <= 1'b0;
            sp_wr_en <= 1'b0;
            exception_number_reg_wr_en <= 1'b0;
            stack_fault <= 1'b0;
            undef_fault <= ok && ns_undef;
            decode_error <= ok && any_err;
            halt_free_debug_trap <= breakpoint_op_go && monitor_mode_sel;
            debug_halt_req <= breakpoint_op_go && !monitor_mode_sel;
            // Store request is a one-cycle strobe; the memory side answers later with st_done
            if (branch_link_exchange_secure_exit_stack) begin
                st_req <= 1'b1;
                st_addr <= sp_val - `BBE_STACK_DEC;
                st_data <= blx_ret;
            end else if (state_r == BBE_ST_RET && st_done && !st_fault) begin
                st_req <= 1'b1;
                st_addr <= frame_r + `BBE_STACK_PSR_OFS;
                st_data <= psr_r;
            end else begin
                st_req <= 1'b0;
            end
            if ((state_r == BBE_ST_RET || state_r == BBE_ST_PSR) && st_done && st_fault) begin
                stack_fault <= 1'b1;
            end
            if (state_r == BBE_FINISH) begin
                sp_wr_en <= 1'b1;
                sp_wr_data <= frame_r;
                stack_fault <= sp_limit_fault;
                wb_en <= 1'b1;
                wb_reg <= 4'he;
                wb_data <= `BBE_SEC_RET_MARK;
                exception_number_reg_wr_en <= hmode_r;
                exception_number_reg_wr_data <= `BBE_EXCEPTION_NUMBER_REG_RESET_NUM;
                branch_en <= 1'b1;
                branch_target <= tgt_r;
                branch_to_ns <= 1'b1;
            end
            if (go && is_bic) begin
                wb_en <= 1'b1;
                wb_reg <= bic_dst;
                wb_data <= bic_res;
                flags_en <= bic_set;
                flags_out <= {bic_res[31], bic_res == 32'h00000000, sh_c, flags_in[0]};
            end
            if (go && is_bl) begin
                wb_en <= 1'b1;
                wb_reg <= 4'he;
                wb_data <= {pc[31:1], 1'b1};
                branch_en <= 1'b1;
                branch_target <= pc + bl_off;
            end
            if (go && is_cb && cb_take) begin
                branch_en <= 1'b1;
                branch_target <= pc + cb_off;
            end
            if (go && is_blx && !branch_link_exchange_secure_exit_stack) begin
                wb_en <= 1'b1;
                wb_reg <= 4'he;
                wb_data <= blx_ret;
                branch_en <= 1'b1;
                branch_target <= tgt;
                invalid_state_fault_kind <= !tgt[0] && !ns_sel;
            end
            if (go && is_bx) begin
                branch_en <= 1'b1;
                branch_target <= tgt;
                exc_return <= is_exc_mark;
                branch_to_ns <= sec_exit && !is_fnc_mark && !is_exc_mark;
                invalid_state_fault_kind <= !tgt[0] && !ns_sel && !is_exc_mark;
            end
        end
    end

    a_bic_result: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_bic
        |=> wb_en && wb_data == ($past(rn_val) & ~$past(sh_val))) else $error("bit clear result wrong");
    a_bic_flags: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_bic
        |=> flags_out[3] == wb_data[31] && flags_out[2] == (wb_data == 32'h00000000)
            && flags_out[0] == $past(flags_in[0])) else $error("bit clear flags wrong");
    a_bic_group: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_bic16
        |=> flags_en == !$past(in_pred_group)) else $error("short bit clear flag setting wrong");
    a_breakpoint_op_monitor: assert property (@(posedge clock) disable iff (!rst_b)
        breakpoint_op_go && monitor_mode_sel
        |=> halt_free_debug_trap && !debug_halt_req) else $error("monitor trap missing");
    a_breakpoint_op_halt: assert property (@(posedge clock) disable iff (!rst_b)
        breakpoint_op_go && !monitor_mode_sel
        |=> debug_halt_req && !halt_free_debug_trap) else $error("halt missing");
    a_breakpoint_op_uncond: assert property (@(posedge clock) disable iff (!rst_b)
        ok && is_breakpoint_op && !cond_pass
        |=> halt_free_debug_trap || debug_halt_req) else $error("breakpoint gated by condition");
    a_bl_offset: assert property (@(posedge clock) disable iff (!rst_b)
        is_bl
        |-> !bl_off[0] && bl_off[31:24] == {8{s_bit}} && bl_off[23] == !(lw[13] ^ s_bit)) else $error("call offset wrong");
    a_bl_target: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_bl
        |=> branch_en && branch_target == $past(pc) + $past(bl_off)) else $error("call target wrong");
    a_bl_link: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_bl
        |=> wb_en && wb_data[0] && wb_reg == 4'he) else $error("link not odd");
    a_xfer_group: assert property (@(posedge clock) disable iff (!rst_b)
        ok && (is_bl || is_bxg) && mid_group
        |=> decode_error && !branch_en && !wb_en) else $error("mid group call not refused");
    a_blx_invalid_state_fault_kind: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_blx && !ns_sel && !tgt[0]
        |=> invalid_state_fault_kind) else $error("even call target not flagged");
    a_ns_undef: assert property (@(posedge clock) disable iff (!rst_b)
        ok && is_bxg && ns_sel && !is_secure
        |=> undef_fault && !branch_en) else $error("undefined missed");
    a_blx_pc: assert property (@(posedge clock) disable iff (!rst_b)
        ok && is_blx && rm_idx == `BBE_PC_REG
        |=> decode_error && !branch_en) else $error("PC target not flagged");
    a_blx_return: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_blx && !branch_link_exchange_secure_exit_stack
        |=> wb_en && wb_data == (($past(pc) - 32'h00000002) | 32'h00000001)) else $error("call return wrong");
    sequence s_ret_stored;
        state_r == BBE_ST_RET && st_done && !st_fault;
    endsequence
    sequence s_psr_stored;
        state_r == BBE_ST_PSR && st_done && !st_fault;
    endsequence
    a_stack_first: assert property (@(posedge clock) disable iff (!rst_b)
        branch_link_exchange_secure_exit_stack
        |=> busy && st_req && st_addr == $past(sp_val) - `BBE_STACK_DEC) else $error("first store wrong");
    a_stack_psr: assert property (@(posedge clock) disable iff (!rst_b)
        s_ret_stored
        |=> st_req && st_addr == frame_r + `BBE_STACK_PSR_OFS && st_data == psr_r) else $error("status store wrong");
    a_skip_second: assert property (@(posedge clock) disable iff (!rst_b)
        state_r == BBE_ST_RET && st_done && st_fault
        |=> !st_req && stack_fault && !sp_wr_en) else $error("store not skipped");
    a_stack_finish: assert property (@(posedge clock) disable iff (!rst_b)
        s_psr_stored
        |=> state_r == BBE_FINISH ##1 sp_wr_en && wb_en && wb_data == `BBE_SEC_RET_MARK) else $error("no marker");
    a_sp_limit: assert property (@(posedge clock) disable iff (!rst_b)
        state_r == BBE_FINISH
        |=> sp_wr_data == $past(frame_r) && stack_fault == $past(sp_limit_fault)) else $error("limit fault lost");
    a_exception_number_reg_hide: assert property (@(posedge clock) disable iff (!rst_b)
        state_r == BBE_FINISH
        |=> exception_number_reg_wr_en == $past(hmode_r) && exception_number_reg_wr_data == 9'h001) else $error("handler number not hidden");
    a_branch_exchange_secure_exit_switch: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_bx && ns_sel && !tgt[0] && !is_fnc_mark && !is_exc_mark
        |=> branch_en && branch_to_ns) else $error("secure exit did not switch");
    a_bx_exc_ret: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_bx && is_exc_mark
        |=> exc_return && !branch_to_ns) else $error("exception return missed");
    a_bx_pc: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_bx && !ns_sel && rm_idx == `BBE_PC_REG && !tgt[0]
        |=> invalid_state_fault_kind) else $error("exchange through PC not flagged");
    a_cb_offset: assert property (@(posedge clock) disable iff (!rst_b)
        is_cb
        |-> cb_off[31:7] == 25'h0000000 && !cb_off[0]) else $error("compare-branch offset wrong");
    a_cb_target: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_cb && cb_take
        |=> branch_en && branch_target == $past(pc) + $past(cb_off)) else $error("compare-branch target wrong");
    a_pred_error: assert property (@(posedge clock) disable iff (!rst_b)
        ok && is_cb && in_pred_group
        |=> decode_error && !branch_en) else $error("group error missed");
    a_cb_flags: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_cb
        |=> !flags_en) else $error("compare-branch touched flags");
    a_cb_branch: assert property (@(posedge clock) disable iff (!rst_b)
        go && is_cb
        |=> branch_en == $past(cb_take)) else $error("compare-branch decision wrong");
endmodule

// file: bbe_exec_bench.sv
// Self-checking bench for the branch and breakpoint execute block
`timescale 1ns/1ps
`include "bbe_cfg.svh"
module bbe_exec_bench;
    import bbe_pkg::*;
    logic clock, rst_b, instr_valid, instr_is_32, cond_pass, in_pred_group, last_in_pred_group, is_secure;
    logic handler_mode, monitor_mode_sel, secure_fp_active_flag, st_done, st_fault, sp_limit_fault;
    logic [31:0] instr, pc, rn_val, rm_val, sp_val, wb_data, branch_target, st_addr, st_data, sp_wr_data;
    logic [8:0] exc_num, exception_number_reg_wr_data;
    logic [3:0] flags_in, wb_reg, flags_out;
    logic [1:0] shift_type;
    logic [5:0] shift_amt;
    logic busy, wb_en, flags_en, branch_en, branch_to_ns, exc_return, invalid_state_fault_kind, undef_fault;
    logic decode_error, halt_free_debug_trap, debug_halt_req, st_req, sp_wr_en, exception_number_reg_wr_en, stack_fault;
    int fails, compares, n, bad;
    logic [31:0] bx_i [8] = '{32'h4710, 32'h4778, 32'h4714, 32'h477c, 32'h478c, 32'h4714, 32'h47f8, 32'h4788};
    logic [31:0] bx_m [8] = '{32'hfffffff9, 32'h1000, 32'h3000, 32'h1000, 32'h4000, 32'h3000, 32'h1000, 32'h2000};
    logic [5:0] bx_e [8] = '{6'h10, 6'h08, 6'h24, 6'h24, 6'h02, 6'h02, 6'h01, 6'h08};
    logic [31:0] bl_i [2] = '{32'hd802f001, 32'hfffff7ff};
    logic [31:0] bl_o [2] = '{32'h00801004, 32'hfffffffe};

    bbe_exec DUT (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr), .instr_is_32(instr_is_32),
        .cond_pass(cond_pass), .in_pred_group(in_pred_group), .last_in_pred_group(last_in_pred_group),
        .is_secure(is_secure), .handler_mode(handler_mode), .monitor_mode_sel(monitor_mode_sel), .pc(pc),
        .rn_val(rn_val), .rm_val(rm_val), .sp_val(sp_val), .exc_num(exc_num), .flags_in(flags_in),
        .secure_fp_active_flag(secure_fp_active_flag), .shift_type(shift_type), .shift_amt(shift_amt),
        .st_done(st_done), .st_fault(st_fault), .sp_limit_fault(sp_limit_fault), .busy(busy), .wb_en(wb_en),
        .wb_reg(wb_reg), .wb_data(wb_data), .flags_en(flags_en), .flags_out(flags_out), .branch_en(branch_en),
        .branch_target(branch_target), .branch_to_ns(branch_to_ns), .exc_return(exc_return),
        .invalid_state_fault_kind(invalid_state_fault_kind), .undef_fault(undef_fault), .decode_error(decode_error),
        .halt_free_debug_trap(halt_free_debug_trap), .debug_halt_req(debug_halt_req), .st_req(st_req),
        .st_addr(st_addr), .st_data(st_data), .sp_wr_en(sp_wr_en), .sp_wr_data(sp_wr_data),
        .exception_number_reg_wr_en(exception_number_reg_wr_en), .exception_number_reg_wr_data(exception_number_reg_wr_data), .stack_fault(stack_fault));

    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end

    task close_out;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Wide enough that enable bits packed above a full data word are still compared
    task check(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One instruction offered for one cycle; outputs sampled once the taking edge has landed
    task go(input logic [31:0] i, input logic w);
        @(posedge clock);
        instr <= i;
        instr_is_32 <= w;
        instr_valid <= 1;
        @(posedge clock);
        instr_valid <= 0;
        #1;
    endtask

    // Memory side of one stack store; waits for the request under a bound
    task st(input logic [31:0] a, input logic [31:0] d, input logic f);
        n = 0;
        while (!(st_req === 1'b1) && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 20) begin
            fails++;
            close_out();
        end
        check("st_addr", a, st_addr);
        check("st_data", d, st_data);
        @(posedge clock);
        st_done <= 1;
        st_fault <= f;
        @(posedge clock);
        st_done <= 0;
        st_fault <= 0;
        #1;
    endtask

    initial begin
        {rst_b, instr_valid, instr_is_32, in_pred_group, last_in_pred_group, is_secure, handler_mode} = 0;
        {monitor_mode_sel, secure_fp_active_flag, st_done, st_fault, sp_limit_fault, shift_type, shift_amt} = 0;
        {instr, rn_val, rm_val, sp_val, exc_num, flags_in} = 0;
        cond_pass = 1;
        pc = 32'h1000;
        fails = 0;
        compares = 0;
        repeat (16) @(posedge clock);
        rst_b <= 1;
        rn_val <= 32'hf0f0000f;
        rm_val <= 32'h0000000f;
        flags_in <= 4'h3;
        go(32'h438a, 0);
        check("bic data", 32'hf0f00000, wb_data);
        check("bic flags", 5'h1b, {flags_en, flags_out});
        rm_val <= 32'hf0f0000f;
        flags_in <= 4'h0;
        go(32'h438a, 0);
        check("bic zero", 5'h14, {flags_en, flags_out});
        rn_val <= 32'h800000ff;
        rm_val <= 32'h1000000f;
        shift_type <= BBE_SH_LSL;
        shift_amt <= 6'h04;
        go(32'h1203ea31, 1);
        check("bic shifted", {4'h2, 32'h8000000f}, {wb_reg, wb_data});
        check("bic carry", 5'h1a, {flags_en, flags_out});
        in_pred_group <= 1;
        go(32'h438a, 0);
        check("bic in group", 0, flags_en);
        cond_pass <= 0;
        for (int k = 0; k < 2; k++) begin
            monitor_mode_sel <= k[0];
            go(k ? 32'hbeff : 32'hbe00, 0);
            check("breakpoint_op", {k[0], !k[0]}, {halt_free_debug_trap, debug_halt_req});
        end
        go(bl_i[0], 1);
        check("bl cond fail", 0, {wb_en, branch_en});
        cond_pass <= 1;
        go(bl_i[0], 1);
        check("bl mid group", 3'h4, {decode_error, wb_en, branch_en});
        last_in_pred_group <= 1;
        go(32'h4710, 0);
        check("bx last in group", 0, decode_error);
        in_pred_group <= 0;
        last_in_pred_group <= 0;
        for (int k = 0; k < 2; k++) begin
            go(bl_i[k], 1);
            check("bl link", {1'b1, 4'he, 32'h1001}, {wb_en, wb_reg, wb_data});
            check("bl target", {1'b1, pc + bl_o[k]}, {branch_en, branch_target});
        end
        rm_val <= 32'h2001;
        go(32'h4788, 0);
        check("blx link", {1'b1, 4'he, 32'h0fff}, {wb_en, wb_reg, wb_data});
        check("blx target", {1'b1, 31'h1000}, {branch_en, branch_target[31:1]});
        for (int k = 0; k < 8; k++) begin
            rm_val <= bx_m[k];
            is_secure <= bx_e[k][5];
            go(bx_i[k], 0);
            check("bx outcome", bx_e[k][4:0], {exc_return, invalid_state_fault_kind, branch_to_ns, undef_fault,
                decode_error});
        end
        // Secure call from handler mode, then the same call with a faulting first store
        {is_secure, handler_mode, secure_fp_active_flag} <= 3'h7;
        {rm_val, sp_val, exc_num} <= {32'h4000, 32'h8000, 9'h023};
        go(32'h478c, 0);
        check("busy", 1, busy);
        st(32'h7ff8, 32'h0fff, 0);
        st(32'h7ffc, 32'h223, 0);
        sp_limit_fault <= 1;
        n = 0;
        while (!(sp_wr_en === 1'b1) && n < 10) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("sp write", {1'b1, 32'h7ff8}, {sp_wr_en, sp_wr_data});
        check("link marker", {1'b1, `BBE_SEC_RET_MARK}, {wb_en, wb_data});
        check("exception_number_reg hide", {1'b1, 9'h001}, {exception_number_reg_wr_en, exception_number_reg_wr_data});
        check("to ns", 2'h3, {branch_en, branch_to_ns});
        check("limit fault", 1, stack_fault);
        sp_limit_fault <= 0;
        go(32'h478c, 0);
        st(32'h7ff8, 32'h0fff, 1);
        bad = 0;
        n = 0;
        repeat (8) begin
            if (st_req === 1'b1 || sp_wr_en === 1'b1) bad++;
            if (stack_fault === 1'b1) n++;
            @(posedge clock);
            #1;
        end
        check("store skipped", 0, bad);
        check("stack fault", 1, n);
        {is_secure, handler_mode} <= 0;
        for (int k = 0; k < 4; k++) begin
            rn_val <= k[0] ? 32'h0 : 32'h5;
            go(k[1] ? 32'hbbf8 : 32'hb3f8, 0);
            check("cb branch", k[1] ^ k[0], branch_en);
            if (k[1] ^ k[0]) check("cb target", pc + 32'h7e, branch_target);
            check("cb flags", 0, flags_en);
        end
        in_pred_group <= 1;
        last_in_pred_group <= 1;
        go(32'hb3f8, 0);
        check("cb in group", 2'h2, {decode_error, branch_en});
        close_out();
    end
endmodule
